/* hdl/codec_ctrl_pkg.sv */
// Purpose: Shared constants and types for the codec control registers 2 to 4
// Assumes: Master clock is the block clock
// Notes:   Widths cover the largest divider product
package codec_ctrl_pkg;

   // Control word register addresses
   localparam logic [2:0] ADDR_CLOCK_FILTER_HOSTPIN = 3'h2;
   localparam logic [2:0] ADDR_POWER_RESET_RATE     = 3'h3;
   localparam logic [2:0] ADDR_FRAME_DIVIDER        = 3'h4;

   // Field positions, control register 2
   localparam int TURBO_BIT      = 7;
   localparam int BYPASS_BIT     = 6;
   localparam int BUS_ADDR_LSB   = 3;
   localparam int SPARE_OUT_BIT  = 2;
   localparam int HOST_CFG_LSB   = 0;
   // Field positions, control register 3
   localparam int POWER_DOWN_LSB = 6;
   localparam int SOFT_RESET_BIT = 5;
   localparam int OSR_LSB        = 3;
   localparam int ASYNC_RATE_LSB = 0;
   // Field positions, control register 4
   localparam int DIV_SELECT_BIT = 7;
   localparam int N_LSB          = 3;
   localparam int P_LSB          = 0;

   // Reset values
   localparam logic [7:0] CLOCK_FILTER_HOSTPIN_RESET = 8'h20;
   localparam logic [7:0] POWER_RESET_RATE_RESET     = 8'h01;
   localparam logic [6:0] M_CODE_RESET               = 7'h10;
   localparam logic [3:0] N_CODE_RESET               = 4'h6;
   localparam logic [2:0] P_CODE_RESET               = 3'h0;

   // Value meant by an all-zero divider code
   localparam logic [7:0] M_ZERO_VALUE = 8'h80;
   localparam logic [7:0] N_ZERO_VALUE = 8'h10;
   localparam logic [7:0] P_ZERO_VALUE = 8'h08;
   localparam logic [7:0] P_COARSE     = 8'h08;
   localparam logic [3:0] ASYNC_ZERO_VALUE = 4'h8;

   // Frame rate scaling
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam logic [9:0] OSR_512    = 10'h200;
   localparam logic [9:0] OSR_256    = 10'h100;
   localparam logic [9:0] OSR_128    = 10'h080;

   // Sampling periods before new divider values apply
   localparam logic [1:0] DIV_UPDATE_PERIODS = 2'h2;

   localparam int FS_DIV_W   = 21;
   localparam int SCLK_DIV_W = 17;

   typedef enum logic [1:0] {
      HOST_I2C,
      HOST_ALT_TWO_WIRE,
      HOST_SPARE_PASS,
      HOST_FRAME_FLAG
   } host_cfg_e;

   typedef struct packed {
      logic [2:0] addr;
      logic       read;
      logic       broadcast;
      logic [2:0] fill;
      logic [7:0] data;
   } ctrl_word_s;

   typedef struct packed {
      logic       adc_off;
      logic       dac_off;
      logic       device_off;
   } power_s;

endpackage

/* hdl/tick_divider.sv */
// Purpose: Free running divider giving one tick every div clock cycles
// Assumes: div is at least one; zero is treated as one
// Notes:   A new div takes effect at once, in the period already under way
`timescale 1ns/100ps
module tick_divider #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] div,
   output logic              tick
);

   logic [W-1:0] count_reg;
   logic         end_now;

   assign end_now = (count_reg + {{(W-1){1'b0}}, 1'b1} >= div);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         count_reg <= '0;
      end else if (end_now) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         tick <= 1'b0;
      end else begin
         tick <= end_now;
      end
   end

endmodule

/* hdl/codec_control_regs_two_to_four.sv */
// Purpose: Control registers 2, 3 and 4 of a voice codec with their clock logic
// Assumes: clk is the master clock; control words arrive already deserialised
// Notes:   Serial frame timing, gain and control register 1 live elsewhere
`timescale 1ns/100ps
module codec_control_regs_two_to_four (
   input  wire logic                       clk,
   input  wire logic                       rst_b,
   input  wire logic                       ctrl_valid,
   input  wire codec_ctrl_pkg::ctrl_word_s ctrl_word,
   output logic                            rd_valid,
   output logic [7:0]                      rd_data,
   input  wire logic                       frame_active,
   input  wire logic [3:0]                 device_address,
   input  wire logic [2:0]                 cascade_count,
   input  wire logic [1:0]                 mode_factor,
   input  wire logic                       rates_differ,
   input  wire logic                       bus_sda_out,
   input  wire logic                       bus_sda_oe,
   input  wire logic                       sda_in,
   input  wire logic                       scl_in,
   output logic                            sda_out,
   output logic                            sda_oe,
   output logic                            sda_bus_in,
   output logic                            serial_out_pass,
   output logic                            serial_out_pass_en,
   output logic                            i2c_mode,
   output logic                            alt_two_wire_mode,
   output logic [6:0]                      bus_address,
   output logic                            filter_bypass,
   output codec_ctrl_pkg::power_s          power_state,
   output logic [9:0]                      oversample_ratio,
   output logic [3:0]                      async_ratio,
   output logic                            coarse_mode,
   output logic                            frame_sync,
   output logic                            bit_clock_tick,
   output logic                            soft_reset_active
);

   // Zero code stands for the field's largest value
   function automatic logic [7:0] field_value(input logic [6:0] code,
                                              input logic [7:0] zero_val);
      field_value = (code == 7'h00) ? zero_val : {1'b0, code};
   endfunction

   function automatic logic [3:0] at_least_one(input logic [3:0] v);
      at_least_one = (v == 4'h0) ? 4'h1 : v;
   endfunction

   logic [7:0] clock_filter_hostpin_control_reg;
   logic [7:0] power_reset_rate_control_reg;
   logic       divider_select_reg;
   logic [6:0] m_pending_reg;
   logic [3:0] n_pending_reg;
   logic [2:0] p_pending_reg;
   logic [6:0] m_active_reg;
   logic [3:0] n_active_reg;
   logic [2:0] p_active_reg;
   logic [1:0] update_wait_reg;
   logic       second_read_reg;
   logic       soft_reset_reg;
   logic       scl_meta_reg;
   logic       scl_sync_reg;
   logic       sda_meta_reg;
   logic       sda_sync_reg;
   logic       core_rst_b;
   logic       wr_en;
   logic       rd_en;
   logic       fs_tick;
   logic [7:0] m_val;
   logic [7:0] n_val;
   logic [7:0] p_val;
   logic [16:0] mnp_product;
   logic [codec_ctrl_pkg::FS_DIV_W-1:0]   fs_div;
   logic [codec_ctrl_pkg::SCLK_DIV_W-1:0] sclk_div;
   logic [codec_ctrl_pkg::SCLK_DIV_W-1:0] sclk_slow_div;
   logic [5:0] bit_scale;
   codec_ctrl_pkg::host_cfg_e host_cfg;

   // Soft reset pulls every register except the pin synchronisers and the pulse itself back to its reset value
   assign core_rst_b = rst_b & ~soft_reset_reg;

   assign wr_en = ctrl_valid & ~ctrl_word.read;
   assign rd_en = ctrl_valid & ctrl_word.read;

   // Control register 2
   always_ff @(posedge clk) begin
      if (!core_rst_b) begin
         clock_filter_hostpin_control_reg <= codec_ctrl_pkg::CLOCK_FILTER_HOSTPIN_RESET;
      end else if (wr_en && ctrl_word.addr == codec_ctrl_pkg::ADDR_CLOCK_FILTER_HOSTPIN) begin
         clock_filter_hostpin_control_reg <= ctrl_word.data;
      end
   end

   // Control register 3; the soft reset bit is never stored
   always_ff @(posedge clk) begin
      if (!core_rst_b) begin
         power_reset_rate_control_reg <= codec_ctrl_pkg::POWER_RESET_RATE_RESET;
      end else if (wr_en && ctrl_word.addr == codec_ctrl_pkg::ADDR_POWER_RESET_RATE) begin
         power_reset_rate_control_reg <= ctrl_word.data
                                         & ~(8'h01 << codec_ctrl_pkg::SOFT_RESET_BIT);
      end
   end

   // Soft reset pulse, one cycle long
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         soft_reset_reg <= 1'b0;
      end else begin
         soft_reset_reg <= ~soft_reset_reg & wr_en
                           & (ctrl_word.addr == codec_ctrl_pkg::ADDR_POWER_RESET_RATE)
                           & ctrl_word.data[codec_ctrl_pkg::SOFT_RESET_BIT];
      end
   end

   assign soft_reset_active = soft_reset_reg;

   // Control register 4 writes land in the pending divider set
   always_ff @(posedge clk) begin
      if (!core_rst_b) begin
         divider_select_reg <= 1'b0;
         m_pending_reg      <= codec_ctrl_pkg::M_CODE_RESET;
         n_pending_reg      <= codec_ctrl_pkg::N_CODE_RESET;
         p_pending_reg      <= codec_ctrl_pkg::P_CODE_RESET;
      end else if (wr_en && ctrl_word.addr == codec_ctrl_pkg::ADDR_FRAME_DIVIDER) begin
         divider_select_reg <= ctrl_word.data[codec_ctrl_pkg::DIV_SELECT_BIT];
         if (ctrl_word.data[codec_ctrl_pkg::DIV_SELECT_BIT]) begin
            m_pending_reg <= ctrl_word.data[6:0];
         end else begin
            n_pending_reg <= ctrl_word.data[codec_ctrl_pkg::N_LSB +: 4];
            p_pending_reg <= ctrl_word.data[codec_ctrl_pkg::P_LSB +: 3];
         end
      end
   end

   // Count sampling periods before the pending set goes live
   always_ff @(posedge clk) begin
      if (!core_rst_b) begin
         update_wait_reg <= 2'h0;
      end else if (wr_en && ctrl_word.addr == codec_ctrl_pkg::ADDR_FRAME_DIVIDER) begin
         update_wait_reg <= codec_ctrl_pkg::DIV_UPDATE_PERIODS;
      end else if (fs_tick && update_wait_reg != 2'h0) begin
         update_wait_reg <= update_wait_reg - 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!core_rst_b) begin
         m_active_reg <= codec_ctrl_pkg::M_CODE_RESET;
         n_active_reg <= codec_ctrl_pkg::N_CODE_RESET;
         p_active_reg <= codec_ctrl_pkg::P_CODE_RESET;
      end else if (fs_tick && update_wait_reg == 2'h1) begin
         m_active_reg <= m_pending_reg;
         n_active_reg <= n_pending_reg;
         p_active_reg <= p_pending_reg;
      end
   end

   // Register 4 read order tracker
   always_ff @(posedge clk) begin
      if (!core_rst_b) begin
         second_read_reg <= 1'b0;
      end else if (ctrl_valid) begin
         second_read_reg <= rd_en & ~second_read_reg
                            & (ctrl_word.addr == codec_ctrl_pkg::ADDR_FRAME_DIVIDER);
      end
   end

   // Read answers, one cycle after the word
   always_ff @(posedge clk) begin
      if (!core_rst_b) begin
         rd_valid <= 1'b0;
         rd_data  <= 8'h00;
      end else begin
         rd_valid <= 1'b0;
         if (rd_en) begin
            unique case (ctrl_word.addr)
               codec_ctrl_pkg::ADDR_CLOCK_FILTER_HOSTPIN: begin
                  rd_valid <= 1'b1;
                  rd_data  <= clock_filter_hostpin_control_reg;
               end
               codec_ctrl_pkg::ADDR_POWER_RESET_RATE: begin
                  rd_valid <= 1'b1;
                  rd_data  <= power_reset_rate_control_reg;
               end
               codec_ctrl_pkg::ADDR_FRAME_DIVIDER: begin
                  rd_valid <= 1'b1;
                  if (second_read_reg) begin
                     rd_data <= {1'b1, m_pending_reg};
                  end else begin
                     rd_data <= {1'b0, n_pending_reg, p_pending_reg};
                  end
               end
               default: begin
                  rd_valid <= 1'b0;
               end
            endcase
         end
      end
   end

   // Divider values from codes
   assign m_val = field_value(m_active_reg, codec_ctrl_pkg::M_ZERO_VALUE);
   assign n_val = field_value({3'h0, n_active_reg}, codec_ctrl_pkg::N_ZERO_VALUE);
   assign p_val = field_value({4'h0, p_active_reg}, codec_ctrl_pkg::P_ZERO_VALUE);
   assign mnp_product = 17'(m_val * n_val * p_val);

   assign fs_div = 21'(mnp_product * codec_ctrl_pkg::FRAME_BITS);

   tick_divider #(
      .W(codec_ctrl_pkg::FS_DIV_W)
   ) fs_gen (
      .clk  (clk),
      .rst_b(core_rst_b),
      .div  (fs_div),
      .tick (fs_tick)
   );

   assign frame_sync = fs_tick;

   // Bit clock divisor from turbo bit
   assign bit_scale     = 6'({2'h0, at_least_one({1'b0, cascade_count})}
                             * {4'h0, (mode_factor == 2'h0) ? 2'h1 : mode_factor});
   assign sclk_slow_div = 17'(mnp_product / {11'h000, bit_scale});
   assign sclk_div      = clock_filter_hostpin_control_reg[codec_ctrl_pkg::TURBO_BIT]
                          ? {9'h000, p_val}
                          : sclk_slow_div;

   tick_divider #(
      .W(codec_ctrl_pkg::SCLK_DIV_W)
   ) sclk_gen (
      .clk  (clk),
      .rst_b(core_rst_b),
      .div  (sclk_div),
      .tick (bit_clock_tick)
   );

   // Pin synchronisers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         scl_meta_reg <= 1'b0;
         scl_sync_reg <= 1'b0;
         sda_meta_reg <= 1'b1;
         sda_sync_reg <= 1'b1;
      end else begin
         scl_meta_reg <= scl_in;
         scl_sync_reg <= scl_meta_reg;
         sda_meta_reg <= sda_in;
         sda_sync_reg <= sda_meta_reg;
      end
   end

   assign sda_bus_in = sda_sync_reg;
   assign host_cfg   = codec_ctrl_pkg::host_cfg_e'(
                          clock_filter_hostpin_control_reg[codec_ctrl_pkg::HOST_CFG_LSB +: 2]);

   // Host pin roles
   always_ff @(posedge clk) begin
      if (!core_rst_b) begin
         sda_out            <= 1'b0;
         sda_oe             <= 1'b0;
         serial_out_pass    <= 1'b0;
         serial_out_pass_en <= 1'b0;
         i2c_mode           <= 1'b0;
         alt_two_wire_mode  <= 1'b0;
      end else begin
         sda_out            <= bus_sda_out;
         sda_oe             <= bus_sda_oe;
         serial_out_pass    <= 1'b0;
         serial_out_pass_en <= 1'b0;
         i2c_mode           <= 1'b0;
         alt_two_wire_mode  <= 1'b0;
         unique case (host_cfg)
            codec_ctrl_pkg::HOST_I2C: begin
               i2c_mode <= 1'b1;
            end
            codec_ctrl_pkg::HOST_ALT_TWO_WIRE: begin
               alt_two_wire_mode <= 1'b1;
            end
            codec_ctrl_pkg::HOST_SPARE_PASS: begin
               sda_out            <= clock_filter_hostpin_control_reg[codec_ctrl_pkg::SPARE_OUT_BIT];
               sda_oe             <= 1'b1;
               serial_out_pass    <= scl_sync_reg;
               serial_out_pass_en <= 1'b1;
            end
            codec_ctrl_pkg::HOST_FRAME_FLAG: begin
               sda_out <= frame_active;
               sda_oe  <= 1'b1;
            end
         endcase
      end
   end

   assign bus_address = {clock_filter_hostpin_control_reg[codec_ctrl_pkg::BUS_ADDR_LSB +: 3],
                         device_address};
   assign filter_bypass = clock_filter_hostpin_control_reg[codec_ctrl_pkg::BYPASS_BIT];

   // Power down decode
   always_comb begin
      power_state.adc_off    = 1'b0;
      power_state.dac_off    = 1'b0;
      power_state.device_off = 1'b0;
      unique case (power_reset_rate_control_reg[codec_ctrl_pkg::POWER_DOWN_LSB +: 2])
         2'h0: begin
         end
         2'h1: begin
            power_state.adc_off = 1'b1;
         end
         2'h2: begin
            power_state.dac_off = 1'b1;
         end
         2'h3: begin
            power_state.adc_off    = 1'b1;
            power_state.dac_off    = 1'b1;
            power_state.device_off = 1'b1;
         end
      endcase
   end

   // Oversampling ratio decode
   always_comb begin
      if (power_reset_rate_control_reg[codec_ctrl_pkg::OSR_LSB]) begin
         oversample_ratio = codec_ctrl_pkg::OSR_512;
      end else if (power_reset_rate_control_reg[codec_ctrl_pkg::OSR_LSB + 1]) begin
         oversample_ratio = codec_ctrl_pkg::OSR_256;
      end else begin
         oversample_ratio = codec_ctrl_pkg::OSR_128;
      end
   end

   // Async rate factor applies only when the channels run at different rates
   always_comb begin
      if (!rates_differ) begin
         async_ratio = 4'h1;
      end else if (power_reset_rate_control_reg[codec_ctrl_pkg::ASYNC_RATE_LSB +: 3] == 3'h0) begin
         async_ratio = codec_ctrl_pkg::ASYNC_ZERO_VALUE;
      end else begin
         async_ratio = {1'b0, power_reset_rate_control_reg[codec_ctrl_pkg::ASYNC_RATE_LSB +: 3]};
      end
   end

   assign coarse_mode = (p_val == codec_ctrl_pkg::P_COARSE);

endmodule

/* test/codec_regs_checker.sv */
// Purpose: Assertions on the codec control register ports
// Assumes: One clock, synchronous active low reset
// Notes:   Bound into the register block
`timescale 1ns/100ps
module codec_regs_checker (
   input wire logic                       clk,
   input wire logic                       rst_b,
   input wire logic                       ctrl_valid,
   input wire codec_ctrl_pkg::ctrl_word_s ctrl_word,
   input wire logic                       rd_valid,
   input wire logic [7:0]                 rd_data,
   input wire logic [3:0]                 device_address,
   input wire logic [6:0]                 bus_address,
   input wire logic                       filter_bypass,
   input wire logic                       sda_out,
   input wire logic                       sda_oe,
   input wire logic                       frame_sync,
   input wire logic [9:0]                 oversample_ratio,
   input wire logic                       soft_reset_active
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic rd_ok, wr2, wr3, rd4, next_second;
   assign rd_ok = ctrl_valid && ctrl_word.read && (ctrl_word.addr inside {3'h2, 3'h3, 3'h4});
   assign wr2 = ctrl_valid && !ctrl_word.read && ctrl_word.addr == 3'h2 && !soft_reset_active;
   assign wr3 = ctrl_valid && !ctrl_word.read && ctrl_word.addr == 3'h3 && !soft_reset_active;
   assign rd4 = ctrl_valid && ctrl_word.read && ctrl_word.addr == 3'h4 && !soft_reset_active;
   // Word order model: any other word restarts the register 4 read pair
   always_ff @(posedge clk) begin
      if (!rst_b || soft_reset_active) begin
         next_second <= 1'b0;
      end else if (ctrl_valid) begin
         next_second <= rd4 && !next_second;
      end
   end
   property p_rd_answer;
      rd_ok && !soft_reset_active |=> rd_valid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_no_answer;
      !rd_ok |=> !rd_valid;
   endproperty
   a_no_answer: assert property (p_no_answer) else $error("answer without read");
   property p_bypass;
      wr2 |=> filter_bypass == $past(ctrl_word.data[6])
         && bus_address[6:4] == $past(ctrl_word.data[5:3]);
   endproperty
   a_bypass: assert property (p_bypass) else $error("reg2 fields wrong");
   property p_dev_addr;
      bus_address[3:0] == device_address;
   endproperty
   a_dev_addr: assert property (p_dev_addr) else $error("bus address low bits");
   property p_spare;
      wr2 && ctrl_word.data[1:0] == 2'h2 |=> ##1 (sda_oe && sda_out == $past(ctrl_word.data[2], 2));
   endproperty
   a_spare: assert property (p_spare) else $error("spare output not on pin");
   property p_osr;
      wr3 && !ctrl_word.data[5] |=> oversample_ratio == ($past(ctrl_word.data[3]) ? 10'h200
         : $past(ctrl_word.data[4]) ? 10'h100 : 10'h080);
   endproperty
   a_osr: assert property (p_osr) else $error("oversample ratio wrong");
   property p_soft;
      wr3 && ctrl_word.data[5] |=> soft_reset_active ##1 (!soft_reset_active && !filter_bypass
         && bus_address[6:4] == 3'h4 && oversample_ratio == 10'h080);
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset wrong");
   property p_r4_first;
      rd4 && !next_second |=> !rd_data[7];
   endproperty
   a_r4_first: assert property (p_r4_first) else $error("first reg4 read wrong");
   property p_r4_second;
      rd4 && next_second |=> rd_data[7];
   endproperty
   a_r4_second: assert property (p_r4_second) else $error("second reg4 read wrong");
   property p_fs_pulse;
      frame_sync |=> !frame_sync;
   endproperty
   a_fs_pulse: assert property (p_fs_pulse) else $error("frame sync too long");
   c_pair: cover property (rd4 && next_second);
   c_soft: cover property (wr3 && ctrl_word.data[5]);
   c_spare: cover property (wr2 && ctrl_word.data[1:0] == 2'h2);
endmodule
bind codec_control_regs_two_to_four codec_regs_checker i_chk (
   .clk(clk), .rst_b(rst_b), .ctrl_valid(ctrl_valid), .ctrl_word(ctrl_word),
   .rd_valid(rd_valid), .rd_data(rd_data), .device_address(device_address),
   .bus_address(bus_address), .filter_bypass(filter_bypass), .sda_out(sda_out),
   .sda_oe(sda_oe), .frame_sync(frame_sync), .oversample_ratio(oversample_ratio),
   .soft_reset_active(soft_reset_active));

/* test/host_dsp_model.sv */
// Purpose: Host side that issues control words
// Assumes: Words change at the falling edge
// Notes:   Idle word lines carry inverted junk
`timescale 1ns/100ps
module host_dsp_model (
   input  wire logic                clk,
   output logic                     ctrl_valid,
   output codec_ctrl_pkg::ctrl_word_s ctrl_word
);
   initial begin
      ctrl_valid = 1'b0;
      ctrl_word  = '0;
   end
   task automatic send(input logic [2:0] a, input logic r, input logic [7:0] d);
      @(negedge clk);
      ctrl_valid = 1'b1;
      ctrl_word = '{addr: a, read: r, broadcast: 1'b0, fill: 3'h7, data: d};
   endtask
   task automatic idle();
      @(negedge clk);
      ctrl_valid = 1'b0;
      ctrl_word = ~ctrl_word;
   endtask
endmodule

/* test/test_codec_control_regs_two_to_four.sv */
// Purpose: Self-checking bench for codec control registers 2 to 4
// Assumes: Host model drives control words
// Notes:   Random fields with fixed seed
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module test_codec_control_regs_two_to_four;
   logic clk, rst_b, ctrl_valid, rd_valid, sda_out, sda_oe, sda_bus_in, serial_out_pass;
   logic serial_out_pass_en, i2c_mode, alt_two_wire_mode, filter_bypass, coarse_mode;
   logic frame_sync, bit_clock_tick, soft_reset_active;
   logic [7:0] rd_data, d2, d3;
   logic [6:0] bus_address;
   logic [9:0] oversample_ratio;
   logic [3:0] async_ratio;
   codec_ctrl_pkg::power_s power_state;
   codec_ctrl_pkg::ctrl_word_s ctrl_word;
   logic [3:0] device_address = 4'h0;
   logic frame_active = 1'b0, rates_differ = 1'b0, bus_sda_out = 1'b0, bus_sda_oe = 1'b0;
   logic sda_in = 1'b1, scl_in = 1'b1, fa_seen = 1'b0;
   int bad_count = 0, checked = 0, i, n;
   host_dsp_model host (.clk(clk), .ctrl_valid(ctrl_valid), .ctrl_word(ctrl_word));
   codec_control_regs_two_to_four i_dut (
      .clk(clk), .rst_b(rst_b), .ctrl_valid(ctrl_valid), .ctrl_word(ctrl_word),
      .rd_valid(rd_valid), .rd_data(rd_data), .frame_active(frame_active),
      .device_address(device_address), .cascade_count(3'h1), .mode_factor(2'h1),
      .rates_differ(rates_differ), .bus_sda_out(bus_sda_out), .bus_sda_oe(bus_sda_oe),
      .sda_in(sda_in), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
      .sda_bus_in(sda_bus_in), .serial_out_pass(serial_out_pass),
      .serial_out_pass_en(serial_out_pass_en), .i2c_mode(i2c_mode),
      .alt_two_wire_mode(alt_two_wire_mode), .bus_address(bus_address),
      .filter_bypass(filter_bypass), .power_state(power_state),
      .oversample_ratio(oversample_ratio), .async_ratio(async_ratio),
      .coarse_mode(coarse_mode), .frame_sync(frame_sync), .bit_clock_tick(bit_clock_tick),
      .soft_reset_active(soft_reset_active));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) fa_seen <= frame_active;
   always @(negedge clk) begin
      device_address <= 4'($urandom);
      frame_active <= 1'($urandom);
      rates_differ <= 1'($urandom);
      {bus_sda_out, bus_sda_oe, sda_in, scl_in} <= 4'($urandom);
   end
   function automatic logic [9:0] osr_of(input logic [1:0] c);
      return c[0] ? 10'h200 : (c[1] ? 10'h100 : 10'h080);
   endfunction
   function automatic int fs_period(input int m, input int nn, input int p);
      return 16 * (m == 0 ? 128 : m) * (nn == 0 ? 16 : nn) * (p == 0 ? 8 : p);
   endfunction
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      host.send(a, 1'b0, d);
      host.idle();
   endtask
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
      host.send(a, 1'b1, 8'($urandom));
      host.idle();
      `CHK("rd_valid", 1'b1, rd_valid)
      `CHK("rd_data", e, rd_data)
   endtask
   task automatic rd4_chk(input logic [7:0] e1, input logic [7:0] e2);
      host.send(3'h4, 1'b1, 8'h00);
      host.send(3'h4, 1'b1, 8'h00);
      `CHK("reg4_first", e1, rd_data)
      host.idle();
      `CHK("reg4_second", e2, rd_data)
   endtask
   task automatic period(input bit bc, output int cnt);
      int k;
      k = 0;
      cnt = 0;
      while (k < 2 && cnt < 40000) begin
         @(negedge clk);
         cnt++;
         if ((bc ? bit_clock_tick : frame_sync) === 1'b1) begin
            k++;
            if (k == 1) cnt = 0;
         end
      end
   endtask
   task automatic finish_test();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #800000;
      bad_count++;
      finish_test();
   end
   initial begin
      void'($urandom(84));
      rst_b = 1'b0;
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
      rd_chk(3'h2, 8'h20);
      rd_chk(3'h3, 8'h01);
      rd4_chk(8'h30, 8'h90);
      `CHK("i2c_mode", 1'b1, i2c_mode)
      `CHK("coarse", 1'b1, coarse_mode)
      host.send(3'h5, 1'b1, 8'h00);
      host.idle();
      `CHK("unmapped", 1'b0, rd_valid)
      for (i = 0; i < 24; i++) begin
         d2 = 8'($urandom) & 8'h7f;
         d3 = (i < 8) ? {i[1:0], 1'b0, i[1:0], i[2:0]} : (8'($urandom) & 8'hdf);
         if (i < 4) d2[1:0] = i[1:0];
         wr(3'h2, d2);
         wr(3'h3, d3);
         #1;
         `CHK("bypass", d2[6], filter_bypass)
         `CHK("bus_addr", {d2[5:3], device_address}, bus_address)
         `CHK("osr", osr_of(d3[4:3]), oversample_ratio)
         `CHK("async", rates_differ ? (d3[2:0] == 3'h0 ? 4'h8 : {1'b0, d3[2:0]}) : 4'h1, async_ratio)
         `CHK("pwr_dev", d3[7:6] == 2'h3, power_state.device_off)
         if (d3[7:6] != 2'h3) `CHK("pwr_path", {d3[7:6] == 2'h1, d3[7:6] == 2'h2}, {power_state.adc_off, power_state.dac_off})
         `CHK("i2c", d2[1:0] == 2'h0, i2c_mode)
         `CHK("alt", d2[1:0] == 2'h1, alt_two_wire_mode)
         if (d2[1:0] == 2'h2) `CHK("sda_spare", {2'h3, d2[2]}, {sda_oe, serial_out_pass_en, sda_out})
         if (d2[1:0] == 2'h3) `CHK("sda_flag", {1'b1, fa_seen}, {sda_oe, sda_out})
         rd_chk(3'h2, d2);
         rd_chk(3'h3, d3);
      end
      period(1'b0, n);
      `CHK("fs_default", fs_period(16, 6, 8), n)
      wr(3'h4, 8'h0b);
      wr(3'h4, 8'h82);
      rd4_chk(8'h0b, 8'h82);
      period(1'b0, n);
      `CHK("fs_hold", fs_period(16, 6, 8), n)
      period(1'b0, n);
      `CHK("fs_new", fs_period(2, 1, 3), n)
      `CHK("fine", 1'b0, coarse_mode)
      period(1'b1, n);
      `CHK("slow_bit", fs_period(2, 1, 3) / 16, n)
      wr(3'h2, 8'h80);
      period(1'b1, n);
      `CHK("turbo_bit", 3, n)
      wr(3'h3, 8'he0);
      repeat (2) @(negedge clk);
      rd_chk(3'h3, 8'h01);
      rd_chk(3'h2, 8'h20);
      rd4_chk(8'h30, 8'h90);
      finish_test();
   end
endmodule
